// File: tb/cpu_model.sv
// model of the core: acknowledges vectors and grants move cycles
// assumes design outputs settle before the falling edge
`timescale 1ns/1ps
module cpu_model
(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       irq_i,
   input  wire logic       move_req_i,
   input  wire logic       ack_on_i,
   input  wire logic [1:0] delay_i,
   output logic            ack_o,
   output logic            grant_o
);
   logic [2:0] wait_q;
   // answer after delay_i extra cycles; ack may be withheld
   always @(negedge ref_clk_i)
   begin
      if (!rst_b_i || !(irq_i || move_req_i)) wait_q = 3'h0;
      else wait_q = wait_q + 3'h1;
      ack_o   <= irq_i && ack_on_i && (wait_q > {1'b0, delay_i});
      grant_o <= move_req_i && (wait_q > {1'b0, delay_i});
   end
   initial
   begin
      ack_o   = 1'b0;
      grant_o = 1'b0;
   end
endmodule : cpu_model

// File: tb/irq_event_checker.sv
// checker: timing, vector and handshake assertions on the controller ports
// assumes it is bound to irq_event_ctl from the bench top
`timescale 1ns/1ps
module irq_event_checker
#(
   parameter int NODES = 16
)
(
   input wire logic                                    ref_clk_i,
   input wire logic                                    rst_b_i,
   input wire irq_event_pkg::node_cfg_type [NODES-1:0] node_cfg_i,
   input wire logic                                    seg_load_i,
   input wire logic [7:0]                              seg_value_i,
   input wire logic                                    trap_i,
   input wire logic [irq_event_pkg::PRIO_W-1:0]        cpu_level_i,
   input wire logic                                    cpu_ack_i,
   input wire logic                                    bus_grant_i,
   input wire logic                                    irq_o,
   input wire logic [irq_event_pkg::ADDR_W-1:0]        vector_addr_o,
   input wire logic [irq_event_pkg::PRIO_W-1:0]        irq_level_o,
   input wire logic                                    move_req_o,
   input wire irq_event_pkg::move_type                 move_o,
   input wire logic [NODES-1:0]                        node_req_o
);
   import irq_event_pkg::*;
   logic [7:0]       seg_q;
   logic             trap_q;
   logic [NODES-1:0] elig;
   // mirror of the segment and of a pending trap
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i) seg_q <= SEG_RESET;
      else if (seg_load_i) seg_q <= seg_value_i;
   end
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i) trap_q <= 1'b0;
      else if (trap_i) trap_q <= 1'b1;
      else if (irq_o) trap_q <= 1'b0;
   end
   // nodes that may win arbitration now
   always_comb
   begin
      for (int i = 0; i < NODES; i++)
         elig[i] = node_req_o[i] & node_cfg_i[i].enable & (node_cfg_i[i].prio > cpu_level_i);
   end
   // ***********************************************
   // assertions
   // ***********************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_reset_clear: assert property ($rose(rst_b_i) |-> !irq_o && node_req_o == '0)
      else $error("flags not clear after reset");
   a_resp_bound: assert property ((|elig) && !irq_o && !move_req_o && !trap_q
      |-> ##[1:8] (irq_o || move_req_o))
      else $error("no service within eight clocks");
   a_move_hold: assert property (move_req_o && !bus_grant_i |=> move_req_o && $stable(move_o))
      else $error("move request dropped before grant");
   a_move_once: assert property (move_req_o && bus_grant_i |=> !move_req_o)
      else $error("move took more than one cycle");
   a_no_branch: assert property (!(irq_o && move_req_o))
      else $error("vector offered during a move");
   a_ack_drop: assert property (irq_o && cpu_ack_i |=> !irq_o)
      else $error("vector held after acknowledge");
   a_irq_bound: assert property ($rose(irq_o) |-> ##[1:7] !irq_o)
      else $error("vector offered too long");
   a_vec_align: assert property (irq_o |-> vector_addr_o[1:0] == 2'h0)
      else $error("vector not four byte spaced");
   a_vec_seg: assert property ($rose(irq_o) |-> vector_addr_o[23:16] == seg_q)
      else $error("vector segment wrong");
   a_irq_level: assert property ($rose(irq_o) |-> (trap_q ? irq_level_o == cpu_level_i
      : irq_level_o > cpu_level_i))
      else $error("vector level wrong");
   c_move: cover property (move_req_o && bus_grant_i);
   c_ack: cover property (irq_o && cpu_ack_i);
   c_trap: cover property ($rose(irq_o) && trap_q);
endmodule : irq_event_checker

// File: tb/tb_top.sv
// bench: random and corner stimulus for the interrupt and transfer block
// assumes cpu_model on the core side and the checker bound below
`timescale 1ns/1ps
module tb_top;
   import irq_event_pkg::*;
   logic               ref_clk_i, rst_b_i, seg_load_i, trap_i, cpu_ack_i, bus_grant_i;
   logic               irq_o, move_req_o, ack_on;
   logic [15:0]        periph_req_i, sw_set_req_i, sw_clr_req_i, node_req_o, chan_load_cnt_i;
   logic [5:0]         ext_pin_i;
   logic [11:0]        ext_edge_sel_i;
   node_cfg_type [15:0] node_cfg_i;
   chan_cfg_type [7:0] chan_cfg_i;
   logic [7:0]         chan_load_i, seg_value_i;
   logic [23:0]        chan_load_src_i, chan_load_dst_i, vector_addr_o;
   logic [23:0]        src_a [8], dst_a [8];
   logic [6:0]         trap_num_i;
   logic [3:0]         cpu_level_i, irq_level_o;
   logic [1:0]         delay, sel;
   logic [127:0]       chan_count_o, cnt_exp;
   move_type           move_o;
   int                 bad_count, tests_run, seed, n, k;
   irq_event_ctl irq_event_ctl_inst (.ref_clk_i, .rst_b_i, .periph_req_i, .ext_pin_i,
      .ext_edge_sel_i, .node_cfg_i, .sw_set_req_i, .sw_clr_req_i, .chan_cfg_i, .chan_load_i,
      .chan_load_src_i, .chan_load_dst_i, .chan_load_cnt_i, .seg_load_i, .seg_value_i, .trap_i,
      .trap_num_i, .cpu_level_i, .cpu_ack_i, .bus_grant_i, .irq_o, .vector_addr_o,
      .irq_level_o, .move_req_o, .move_o, .node_req_o, .chan_count_o);
   cpu_model cpu_model_inst (.ref_clk_i, .rst_b_i, .irq_i(irq_o), .move_req_i(move_req_o),
      .ack_on_i(ack_on), .delay_i(delay), .ack_o(cpu_ack_i), .grant_o(bus_grant_i));
   initial
   begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   // ***********************************************
   // helpers
   // ***********************************************
   task cyc(input int c);
      repeat (c) @(negedge ref_clk_i);
   endtask : cyc
   task complete_run;
      if (bad_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   task check(input logic [127:0] seen, input logic [127:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // wait: 0 vector up, 1 move up, 2 move down, 3 vector down
   task wait_for(input int w);
      int t;
      t = 0;
      while ((w == 0 ? irq_o : w == 1 ? move_req_o : w == 2 ? !move_req_o : !irq_o) !== 1'b1)
      begin
         cyc(1);
         t++;
         if (t > 40)
         begin
            bad_count++;
            complete_run;
         end
      end
   endtask : wait_for
   function logic [23:0] vec_exp(input logic [6:0] t);
      return {seg_value_i, 7'h00, t, 2'h0};
   endfunction : vec_exp
   task pulse_req(input int i, input logic sw);
      if (sw) sw_set_req_i[i] = 1'b1;
      else periph_req_i[i] = 1'b1;
      cyc(1);
      sw_set_req_i = '0;
      periph_req_i = '0;
   endtask : pulse_req
   task serve(input int i);
      wait_for(0);
      check(vector_addr_o, vec_exp(node_cfg_i[i].trap));
      check(irq_level_o, node_cfg_i[i].prio);
      check(node_req_o[i], 1'b0);
      wait_for(3);
      cyc(1);
   endtask : serve
   task move_chk(input int i, input logic [23:0] s, input logic [23:0] d, input logic w);
      cyc(3);
      pulse_req(i, 1'b0);
      wait_for(1);
      check(move_o, {s, d, w});
      check(node_req_o[i], 1'b0);
      wait_for(2);
   endtask : move_chk
   // ***********************************************
   // main sequence
   // ***********************************************
   initial
   begin
      {rst_b_i, seg_load_i, trap_i, periph_req_i, sw_set_req_i, sw_clr_req_i} = '0;
      {ext_pin_i, ext_edge_sel_i, chan_cfg_i, chan_load_i, seg_value_i, trap_num_i} = '0;
      {chan_load_src_i, chan_load_dst_i, chan_load_cnt_i, cpu_level_i, delay} = '0;
      {bad_count, tests_run, ack_on, seed} = {32'h0, 32'h0, 1'b1, 32'd79};
      for (k = 0; k < 16; k++)
         node_cfg_i[k] = {1'b1, 4'h1, 1'b0, 3'h0, 7'(8'h18 + k)};
      cyc(2);
      rst_b_i = 1'b1;
      cyc(1);
      check({irq_o, move_req_o, node_req_o}, '0);
      check(chan_count_o, '0);
      seg_value_i = 8'($random(seed));
      seg_load_i = 1'b1;
      cyc(1);
      seg_load_i = 1'b0;
      for (k = 0; k < 12; k++)
      begin
         n = {$random(seed)} % 16;
         node_cfg_i[n].prio = 4'({$random(seed)} % 15 + 1);
         delay = 2'($random(seed));
         pulse_req(n, k[0]);
         serve(n);
      end
      {node_cfg_i[4].prio, node_cfg_i[9].prio, node_cfg_i[2].prio, node_cfg_i[6].prio} = 16'h3C77;
      sw_set_req_i = 16'h0254;
      cyc(1);
      sw_set_req_i = '0;
      serve(9);
      serve(2);
      serve(6);
      serve(4);
      cpu_level_i = 4'h5;
      node_cfg_i[1].prio = 4'h5;
      pulse_req(1, 1'b1);
      cyc(12);
      check({irq_o, node_req_o[1]}, 2'h1);
      node_cfg_i[1].prio = 4'h6;
      serve(1);
      cpu_level_i = 4'h3;
      for (k = 0; k < 4; k++)
      begin
         trap_num_i = k == 0 ? 7'h7F : 7'($random(seed));
         trap_i = 1'b1;
         cyc(1);
         trap_i = 1'b0;
         wait_for(0);
         check({irq_level_o, vector_addr_o}, {cpu_level_i, vec_exp(trap_num_i)});
         wait_for(3);
         cyc(3);
      end
      cpu_level_i = 4'h0;
      for (k = 0; k < 6; k++)
      begin
         node_cfg_i[k].enable = 1'b0;
         sel = 2'(k % 3 + 1);
         ext_edge_sel_i[2*k +: 2] = sel;
         cyc(2);
         ext_pin_i[k] = 1'b1;
         cyc(4);
         check(node_req_o[k], sel[0]);
         sw_clr_req_i[k] = 1'b1;
         cyc(1);
         sw_clr_req_i[k] = 1'b0;
         ext_pin_i[k] = 1'b0;
         cyc(4);
         check(node_req_o[k], sel[1]);
         sw_clr_req_i[k] = 1'b1;
         cyc(1);
         sw_clr_req_i[k] = 1'b0;
         node_cfg_i[k].enable = 1'b1;
      end
      for (k = 0; k < 8; k++)
      begin
         src_a[k] = 24'($random(seed));
         dst_a[k] = 24'($random(seed));
         {chan_load_src_i, chan_load_dst_i, chan_load_cnt_i} = {src_a[k], dst_a[k], 16'(k + 1)};
         cnt_exp[16*k +: 16] = 16'(k + 1);
         chan_load_i = 8'h01 << k;
         cyc(1);
      end
      chan_load_i = 8'h00;
      cyc(1);
      check(chan_count_o, cnt_exp);
      {chan_cfg_i[1], chan_cfg_i[4]} = 8'hC7;
      {node_cfg_i[3].use_transfer, node_cfg_i[3].chan} = 4'h9;
      {node_cfg_i[10].use_transfer, node_cfg_i[10].chan} = 4'hC;
      move_chk(3, src_a[1], dst_a[1], 1'b1);
      check(chan_count_o[31:16], 16'h0001);
      move_chk(3, src_a[1] + 24'h2, dst_a[1], 1'b1);
      wait_for(0);
      check({chan_count_o[31:16], vector_addr_o}, {16'h0, vec_exp(node_cfg_i[3].trap)});
      wait_for(3);
      move_chk(10, src_a[4], dst_a[4], 1'b0);
      move_chk(10, src_a[4] + 24'h1, dst_a[4] + 24'h1, 1'b0);
      check(chan_count_o[79:64], 16'h0005);
      cyc(3);
      ack_on = 1'b0;
      pulse_req(5, 1'b1);
      wait_for(0);
      cyc(9);
      check({irq_o, node_req_o[5]}, 2'h0);
      complete_run;
   end
endmodule : tb_top
bind irq_event_ctl irq_event_checker #(.NODES(NODES)) irq_event_checker_inst (.ref_clk_i,
   .rst_b_i, .node_cfg_i, .seg_load_i, .seg_value_i, .trap_i, .cpu_level_i, .cpu_ack_i,
   .bus_grant_i, .irq_o, .vector_addr_o, .irq_level_o, .move_req_o, .move_o, .node_req_o);

// File: verilog/edge_detect.sv
// edge detector for one fast external input with programmable edge choice
// assumes the input pin is already synchronous to ref_clk_i
`timescale 1ns/1ps
module edge_detect
(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       pin_i,
   input  wire logic [1:0] edge_sel_i,
   output logic            hit_o
);
   import irq_event_pkg::*;
   logic prev_q;

   // previous pin level
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
         prev_q <= 1'b0;
      else
         prev_q <= pin_i;
   end

   // edge match against the selected polarity
   always_comb
   begin
      hit_o = 1'b0;
      if (edge_sel_i == EDGE_RISE)
         hit_o = pin_i & ~prev_q;
      else if (edge_sel_i == EDGE_FALL)
         hit_o = ~pin_i & prev_q;
      else if (edge_sel_i == EDGE_BOTH)
         hit_o = pin_i ^ prev_q;
   end
endmodule : edge_detect

// File: verilog/irq_event_ctl.sv
// interrupt controller with event transfer channels, node request flags and arbitration
// assumes the core acknowledges vectors and grants one bus cycle for a move
`timescale 1ns/1ps
module irq_event_ctl
#(
   parameter int NODES = irq_event_pkg::NODE_COUNT,
   parameter int CHANS = irq_event_pkg::CHAN_COUNT,
   parameter int EXT_INPUTS = 6
)
(
   input  wire logic                                  ref_clk_i,
   input  wire logic                                  rst_b_i,
   input  wire logic [NODES-1:0]                      periph_req_i,
   input  wire logic [EXT_INPUTS-1:0]                 ext_pin_i,
   input  wire logic [2*EXT_INPUTS-1:0]               ext_edge_sel_i,
   input  wire irq_event_pkg::node_cfg_type [NODES-1:0] node_cfg_i,
   input  wire logic [NODES-1:0]                      sw_set_req_i,
   input  wire logic [NODES-1:0]                      sw_clr_req_i,
   input  wire irq_event_pkg::chan_cfg_type [CHANS-1:0] chan_cfg_i,
   input  wire logic [CHANS-1:0]                      chan_load_i,
   input  wire logic [irq_event_pkg::ADDR_W-1:0]      chan_load_src_i,
   input  wire logic [irq_event_pkg::ADDR_W-1:0]      chan_load_dst_i,
   input  wire logic [15:0]                           chan_load_cnt_i,
   input  wire logic                                  seg_load_i,
   input  wire logic [7:0]                            seg_value_i,
   input  wire logic                                  trap_i,
   input  wire logic [irq_event_pkg::TRAP_W-1:0]      trap_num_i,
   input  wire logic [irq_event_pkg::PRIO_W-1:0]      cpu_level_i,
   input  wire logic                                  cpu_ack_i,
   input  wire logic                                  bus_grant_i,
   output logic                                       irq_o,
   output logic [irq_event_pkg::ADDR_W-1:0]           vector_addr_o,
   output logic [irq_event_pkg::PRIO_W-1:0]           irq_level_o,
   output logic                                       move_req_o,
   output irq_event_pkg::move_type                    move_o,
   output logic [NODES-1:0]                           node_req_o,
   output logic [CHANS*16-1:0]                        chan_count_o
);
   import irq_event_pkg::*;

   // ******************************************************
   // parameter checks
   // ******************************************************
   // refuse counts that the fixed node and channel logic cannot serve
   if (NODES != 16 || CHANS != 8 || EXT_INPUTS < 1 || EXT_INPUTS > NODES)
   begin : g_bad_params
      $error("unsupported node or channel count");
   end

   // ******************************************************
   // storage
   // ******************************************************
   logic [NODES-1:0]        req_q;
   logic [7:0]              seg_q;
   logic [ADDR_W-1:0]       src_q [CHANS];
   logic [ADDR_W-1:0]       dst_q [CHANS];
   logic [15:0]             cnt_q [CHANS];
   ctl_state_type           state_q;
   logic [NODE_IDX_W-1:0]   sel_q;
   logic [3:0]              wait_q;
   logic                    trap_pend_q;
   logic [TRAP_W-1:0]       trap_num_q;
   logic [EXT_INPUTS-1:0]   ext_hit;
   logic [NODES-1:0]        set_vec;
   logic                    win_valid;
   logic [NODE_IDX_W-1:0]   win_idx;
   logic [PRIO_W-1:0]       win_prio;
   logic                    start_node;
   logic                    to_zero;
   logic [CHAN_IDX_W-1:0]   cur_chan;

   // vector address from segment and trap number
   function automatic logic [ADDR_W-1:0] vec_addr(input logic [7:0] seg,
                                                   input logic [TRAP_W-1:0] num);
      vec_addr = {seg, 16'({num, 2'b00})};
   endfunction : vec_addr

   // ******************************************************
   // edge detectors for fast inputs
   // ******************************************************
   genvar g;
   generate
      for (g = 0; g < EXT_INPUTS; g++)
      begin : g_ext
         edge_detect u_edge
         (
            .ref_clk_i  (ref_clk_i),
            .rst_b_i    (rst_b_i),
            .pin_i      (ext_pin_i[g]),
            .edge_sel_i (ext_edge_sel_i[2*g +: 2]),
            .hit_o      (ext_hit[g])
         );
      end
   endgenerate

   // request sources merged per node
   always_comb
   begin
      set_vec = periph_req_i | sw_set_req_i;
      set_vec[EXT_INPUTS-1:0] = set_vec[EXT_INPUTS-1:0] | ext_hit;
   end

   // ******************************************************
   // arbitration
   // ******************************************************
   // highest enabled pending priority above the running level wins
   always_comb
   begin
      win_valid = 1'b0;
      win_idx   = '0;
      win_prio  = PRIO_IDLE;
      for (int i = 0; i < NODES; i++)
      begin
         if (req_q[i] && node_cfg_i[i].enable && node_cfg_i[i].prio > cpu_level_i
             && (!win_valid || node_cfg_i[i].prio > win_prio))
         begin
            win_valid = 1'b1;
            win_idx   = NODE_IDX_W'(i);
            win_prio  = node_cfg_i[i].prio;
         end
      end
   end

   assign start_node = (state_q == ST_IDLE) && win_valid && !trap_pend_q;
   assign cur_chan   = node_cfg_i[sel_q].chan;
   assign to_zero    = (cnt_q[cur_chan] == 16'h0001) && !chan_cfg_i[cur_chan].continuous;

   // ******************************************************
   // request flags
   // ******************************************************
   // hardware set wins over clear by service or software
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
         req_q <= '0;
      else
      begin
         for (int i = 0; i < NODES; i++)
         begin
            if (set_vec[i])
               req_q[i] <= 1'b1;
            else if (start_node && win_idx == NODE_IDX_W'(i))
               req_q[i] <= 1'b0;
            else if (sw_clr_req_i[i])
               req_q[i] <= 1'b0;
         end
      end
   end

   // vector segment register
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
         seg_q <= SEG_RESET;
      else if (seg_load_i)
         seg_q <= seg_value_i;
   end

   // pending software trap
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         trap_pend_q <= 1'b0;
         trap_num_q  <= '0;
      end
      else if (trap_i)
      begin
         trap_pend_q <= 1'b1;
         trap_num_q  <= trap_num_i;
      end
      else if (state_q == ST_IDLE)
         trap_pend_q <= 1'b0;
   end

   // ******************************************************
   // channel pointers and counters
   // ******************************************************
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         for (int c = 0; c < CHANS; c++)
         begin
            src_q[c] <= '0;
            dst_q[c] <= '0;
            cnt_q[c] <= CNT_RESET;
         end
      end
      else
      begin
         for (int c = 0; c < CHANS; c++)
         begin
            if (chan_load_i[c])
            begin
               src_q[c] <= chan_load_src_i;
               dst_q[c] <= chan_load_dst_i;
               cnt_q[c] <= chan_load_cnt_i;
            end
            else if (state_q == ST_MOVE && bus_grant_i && cur_chan == CHAN_IDX_W'(c))
            begin
               if (chan_cfg_i[c].inc_src)
                  src_q[c] <= src_q[c] + (chan_cfg_i[c].word ? ADDR_W'(2) : ADDR_W'(1));
               if (chan_cfg_i[c].inc_dst)
                  dst_q[c] <= dst_q[c] + (chan_cfg_i[c].word ? ADDR_W'(2) : ADDR_W'(1));
               if (!chan_cfg_i[c].continuous && cnt_q[c] != 16'h0000)
                  cnt_q[c] <= cnt_q[c] - 16'h0001;
            end
         end
      end
   end

   // ******************************************************
   // service sequencer
   // ******************************************************
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         state_q       <= ST_IDLE;
         sel_q         <= '0;
         wait_q        <= '0;
         irq_o         <= 1'b0;
         vector_addr_o <= '0;
         irq_level_o   <= PRIO_IDLE;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               wait_q <= '0;
               if (trap_pend_q)
               begin
                  irq_o         <= 1'b1;
                  vector_addr_o <= vec_addr(seg_q, trap_num_q);
                  irq_level_o   <= cpu_level_i;
                  state_q       <= ST_VECTOR;
               end
               else if (win_valid)
               begin
                  sel_q <= win_idx;
                  if (node_cfg_i[win_idx].use_transfer)
                     state_q <= ST_MOVE;
                  else
                  begin
                     irq_o         <= 1'b1;
                     vector_addr_o <= vec_addr(seg_q, node_cfg_i[win_idx].trap);
                     irq_level_o   <= win_prio;
                     state_q       <= ST_VECTOR;
                  end
               end
            end
            ST_MOVE:
            begin
               if (bus_grant_i)
               begin
                  if (to_zero)
                  begin
                     irq_o         <= 1'b1;
                     vector_addr_o <= vec_addr(seg_q, node_cfg_i[sel_q].trap);
                     irq_level_o   <= node_cfg_i[sel_q].prio;
                     state_q       <= ST_VECTOR;
                  end
                  else
                     state_q <= ST_IDLE;
               end
            end
            ST_VECTOR:
            begin
               wait_q <= wait_q + 4'h1;
               if (cpu_ack_i || wait_q == 4'(RESPONSE_CLKS - 2))
               begin
                  irq_o   <= 1'b0; // core takes it or it times out and is dropped
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // move request towards the core bus, held until granted
   always_comb
   begin
      move_req_o  = (state_q == ST_MOVE);
      move_o.src  = src_q[cur_chan];
      move_o.dst  = dst_q[cur_chan];
      move_o.word = chan_cfg_i[cur_chan].word;
   end

   // status views
   always_comb
   begin
      node_req_o = req_q;
      for (int c = 0; c < CHANS; c++)
         chan_count_o[16*c +: 16] = cnt_q[c];
   end
endmodule : irq_event_ctl

// File: verilog/irq_event_pkg.sv
// package: constants and carrier types for the interrupt and event transfer block
// assumes a single 25 MHz clock domain and no register bus
package irq_event_pkg;
   localparam int          NODE_COUNT     = 16;
   localparam int          CHAN_COUNT     = 8;
   localparam int          NODE_IDX_W     = 4;
   localparam int          CHAN_IDX_W     = 3;
   localparam int          PRIO_W         = 4;
   localparam int          TRAP_W         = 7;
   localparam int          ADDR_W         = 24;
   localparam int          RESPONSE_CLKS  = 8;
   localparam logic [1:0]  EDGE_RISE      = 2'h1;
   localparam logic [1:0]  EDGE_FALL      = 2'h2;
   localparam logic [1:0]  EDGE_BOTH      = 2'h3;
   localparam logic [1:0]  VEC_SHIFT      = 2'h2;
   localparam logic [7:0]  SEG_RESET      = 8'h00;
   localparam logic [15:0] CNT_RESET      = 16'h0000;
   localparam logic [3:0]  PRIO_IDLE      = 4'h0;

   // per node configuration as software programs it
   typedef struct packed {
      logic                  enable;
      logic [PRIO_W-1:0]     prio;
      logic                  use_transfer;
      logic [CHAN_IDX_W-1:0] chan;
      logic [TRAP_W-1:0]     trap;
   } node_cfg_type;

   // per channel configuration
   typedef struct packed {
      logic       word;
      logic       inc_src;
      logic       inc_dst;
      logic       continuous;
   } chan_cfg_type;

   // one memory move request to the core bus
   typedef struct packed {
      logic [ADDR_W-1:0] src;
      logic [ADDR_W-1:0] dst;
      logic              word;
   } move_type;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_WAIT    = 2'b01,
      ST_MOVE    = 2'b10,
      ST_VECTOR  = 2'b11
   } ctl_state_type;
endpackage : irq_event_pkg
